// ==== bench/hif_frame_model.sv ====
`timescale 1ns/1ns
// Framing side of the buffer: feeds received bytes and pops transmit bytes.
module hif_frame_model
    import hif_pkg::*;
(
    input wire logic aclk,
    output logic rx_start,
    output logic link_wr,
    output logic [7:0] link_wdata,
    output logic link_rd,
    input wire logic [7:0] link_rdata
);
    initial begin
        rx_start = 1'b0;
        link_wr = 1'b0;
        link_wdata = 8'h00;
        link_rd = 1'b0;
    end
    task automatic begin_rx();
        rx_start <= 1'b1;
        @(posedge aclk);
        rx_start <= 1'b0;
        @(posedge aclk);
    endtask
    // Data is inverted after the strobe so a late sample cannot pass.
    task automatic put(input logic [7:0] b);
        link_wr <= 1'b1;
        link_wdata <= b;
        @(posedge aclk);
        link_wr <= 1'b0;
        link_wdata <= ~b;
        @(posedge aclk);
    endtask
    task automatic get(output logic [7:0] b);
        link_rd <= 1'b1;
        @(posedge aclk);
        link_rd <= 1'b0;
        @(posedge aclk);
        b = link_rdata;
    endtask
endmodule

// ==== bench/hif_irq_ctrl_bench.sv ====
`timescale 1ns/1ns
module hif_irq_ctrl_bench;
    import hif_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, rb;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, irq, rx_start, link_wr, link_rd;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] link_wdata, link_rdata;
    logic [7:0] ev [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    int errors = 0, checks_done = 0, cycles = 0;
    always #50 aclk = ~aclk;

    hif_irq_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .evt_main(ev[0]), .evt_timer(ev[1]), .evt_error(ev[2]),
        .evt_target(ev[3]), .rx_start(rx_start), .link_wr(link_wr),
        .link_wdata(link_wdata), .link_rd(link_rd), .link_rdata(link_rdata), .irq(irq));
    hif_frame_model m_u (.aclk(aclk), .rx_start(rx_start), .link_wr(link_wr),
        .link_wdata(link_wdata), .link_rd(link_rd), .link_rdata(link_rdata));

    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", RESP_OKAY, 32'(bresp));
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk("rdata", e, rdata);
        chk("rresp", 32'(r), 32'(rresp));
        @(posedge aclk);
    endtask
    // Three edges let the flag and then the registered line settle.
    task automatic pulse(input int g, input logic [7:0] v);
        ev[g] <= v;
        @(posedge aclk);
        ev[g] <= 8'h00;
        repeat (2) @(posedge aclk);
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 4; i++)
            rd(ADDR_MASK_MAIN + 8'(4 * i), 32'h0, RESP_OKAY);
        rd(ADDR_WATER, 32'h40, RESP_OKAY);
        rd(8'h3C, 32'h0, RESP_SLVERR);
        pulse(0, 8'h01);
        chk("irq", 32'h1, 32'(irq));
        rd(ADDR_IRQ_MAIN, 32'h01, RESP_OKAY);
        chk("irq", 32'h0, 32'(irq));
        rd(ADDR_IRQ_MAIN, 32'h00, RESP_OKAY);
        pulse(1, 8'h02);
        pulse(2, 8'h04);
        rd(ADDR_IRQ_TIMER, 32'h02, RESP_OKAY);
        chk("irq", 32'h1, 32'(irq));
        rd(ADDR_IRQ_ERROR, 32'h04, RESP_OKAY);
        chk("irq", 32'h0, 32'(irq));
        wr(ADDR_MASK_MAIN, 32'h02);
        pulse(0, 8'h02);
        chk("irq", 32'h0, 32'(irq));
        wr(ADDR_MASK_MAIN, 32'h00);
        chk("irq", 32'h1, 32'(irq));
        wr(ADDR_MASK_MAIN, 32'h02);
        rd(ADDR_IRQ_MAIN, 32'h02, RESP_OKAY);
        wr(ADDR_MASK_MAIN, 32'h00);
        chk("irq", 32'h0, 32'(irq));
        ev[0] <= 8'h04;
        fork
            rd(ADDR_IRQ_MAIN, 32'h00, RESP_OKAY);
            begin
                @(posedge aclk);
                ev[0] <= 8'h00;
            end
        join
        chk("irq", 32'h1, 32'(irq));
        rd(ADDR_IRQ_MAIN, 32'h04, RESP_OKAY);
        for (int c = 1; c < 4; c++) begin
            pulse(3, 8'h01);
            chk("irq", 32'h1, 32'(irq));
            wr(ADDR_CMD, 32'(c));
            chk("irq", 32'h0, 32'(irq));
            rd(ADDR_IRQ_TARGET, 32'h0, RESP_OKAY);
        end
        // The water event would otherwise raise the line during buffer traffic.
        wr(ADDR_MASK_MAIN, 32'h08);
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_BUF_DATA, 32'hA1);
        wr(ADDR_BUF_DATA, 32'hB2);
        rd(ADDR_BUF_STAT1, 32'h2, RESP_OKAY);
        m_u.get(rb);
        chk("link", 32'hA1, 32'(rb));
        m_u.get(rb);
        chk("link", 32'hB2, 32'(rb));
        m_u.get(rb);
        chk("link", 32'h00, 32'(rb));
        rd(ADDR_BUF_STAT2, 32'h10, RESP_OKAY);
        wr(ADDR_CMD, 32'h3);
        rd(ADDR_BUF_STAT2, 32'h00, RESP_OKAY);
        for (int i = 0; i < 513; i++)
            wr(ADDR_BUF_DATA, 32'(i[7:0]));
        rd(ADDR_BUF_STAT2, 32'h22, RESP_OKAY);
        rd(ADDR_BUF_STAT1, 32'h00, RESP_OKAY);
        wr(ADDR_CMD, 32'h3);
        rd(ADDR_BUF_STAT2, 32'h00, RESP_OKAY);
        wr(ADDR_CTRL, 32'h0);
        m_u.begin_rx();
        m_u.put(8'h5A);
        m_u.put(8'hC3);
        rd(ADDR_BUF_STAT1, 32'h2, RESP_OKAY);
        rd(ADDR_BUF_DATA, 32'h5A, RESP_OKAY);
        rd(ADDR_BUF_DATA, 32'hC3, RESP_OKAY);
        rd(ADDR_BUF_DATA, 32'h00, RESP_OKAY);
        rd(ADDR_BUF_STAT2, 32'h10, RESP_OKAY);
        m_u.begin_rx();
        rd(ADDR_BUF_STAT2, 32'h00, RESP_OKAY);
        test_done();
    end
endmodule

bind hif_irq_ctrl hif_irq_ctrl_sva chk_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .irq(irq));

// ==== bench/hif_irq_ctrl_sva.sv ====
`timescale 1ns/1ns
module hif_irq_ctrl_sva
    import hif_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire aw_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

    AST_RST_IRQ: assert property (disable iff (1'b0) !aresetn |=> !irq)
        else $error("irq high after a reset edge");
    AST_B_AFTER: assert property (aw_hs |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_R_LAT: assert property (ar_hs && s_axi_araddr != ADDR_BUF_DATA |=> s_axi_rvalid)
        else $error("register read late");
    AST_R_BUF: assert property (ar_hs && s_axi_araddr == ADDR_BUF_DATA |=>
        !s_axi_rvalid ##1 s_axi_rvalid) else $error("buffer read timing wrong");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    AST_UNMAP: assert property (ar_hs && s_axi_araddr == 8'h3C |=>
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
    // A fall is only legal after a status read, a mask write or a command; a read clears
    // two edges before the fall is seen, a write three.
    AST_IRQ_FALL: assert property ($fell(irq) |->
        $past(ar_hs, 2) || $past(s_axi_wvalid, 3))
        else $error("irq fell without host access");

    cover property ($rose(irq));
    cover property ($fell(irq));
    cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

// ==== core/hif_buffer.sv ====
`timescale 1ns/1ns
module hif_buffer
    import hif_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    hif_buf_if.buffer hb,
    input wire logic tx_mode,
    input wire logic [8:0] water_level,
    input wire logic link_wr,
    input wire logic [7:0] link_wdata,
    input wire logic link_rd,
    output logic [7:0] link_rdata
);
    logic [7:0] mem [BUF_DEPTH];
    logic [PTR_W-1:0] wptr_q;
    logic [PTR_W-1:0] rptr_q;
    logic [CNT_W-1:0] cnt_q;
    logic ovf_q;
    logic udf_q;
    logic [7:0] lrd_q;
    logic water_q;

    // In transmit the host fills and the link drains; in receive it is reversed.
    wire logic wr = tx_mode ? hb.host_wr : link_wr;
    wire logic [7:0] wdata = tx_mode ? hb.host_wdata : link_wdata;
    wire logic rd = tx_mode ? link_rd : hb.host_rd;
    wire logic empty = (cnt_q == '0);
    wire logic full = (cnt_q == CNT_W'(BUF_DEPTH));
    wire logic do_wr = wr && !full;
    wire logic do_rd = rd && !empty;
    wire logic [CNT_W-1:0] wl = {1'b0, water_level};
    wire logic water_now = tx_mode ? (cnt_q < wl) : (cnt_q > wl);
    // The host pop is read out combinationally, so the byte is there in the cycle the bus
    // captures it; a registered copy would hand over the previous pop. Empty reads give zero.
    wire logic [7:0] host_pop = (!tx_mode && !empty) ? mem[rptr_q] : 8'h00;

    assign hb.count = cnt_q;
    assign hb.overflow = ovf_q;
    assign hb.underflow = udf_q;
    assign hb.host_rdata = host_pop;
    assign link_rdata = lrd_q;
    assign hb.water_evt = water_now && !water_q;

    always_ff @(posedge aclk) begin
        if (do_wr) begin
            mem[wptr_q] <= wdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || hb.flush) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q <= '0;
            ovf_q <= 1'b0;
            udf_q <= 1'b0;
            lrd_q <= 8'h00;
            water_q <= 1'b0;
        end else begin
            water_q <= water_now;
            if (do_wr) begin
                wptr_q <= wptr_q + PTR_W'(1);
            end
            if (do_rd) begin
                rptr_q <= rptr_q + PTR_W'(1);
            end
            cnt_q <= cnt_q + CNT_W'(do_wr) - CNT_W'(do_rd);
            if (wr && full) begin
                ovf_q <= 1'b1;
            end
            if (rd && empty) begin
                udf_q <= 1'b1;
            end
            // Empty link pops return zero rather than stale data.
            if (link_rd) begin
                lrd_q <= (tx_mode && !empty) ? mem[rptr_q] : 8'h00;
            end
        end
    end
endmodule

// ==== core/hif_irq_ctrl.sv ====
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
// Functional notes
// - Four separate interrupt status groups kept.
// - Event sets flag, raises line unless masked.
// - Reading group returns flags then clears them.
// - Line falls after last unmasked flag read.
// - Masked source still records its flag.
// - Reads report and clear masked flags too.
// - Unmasking set flag raises line immediately.
// - Defaults, halt, flush clear all flags.
// - Shared 512-byte transmit and receive buffer.
// - Transmit moves loaded bytes out in order.
// - Reception stores demodulated bytes in buffer.
// - Overflow and underflow in second status register.
// - Overflow when write exceeds 512 bytes.
// - Underflow when buffer read while empty.
// - Receive start resets pointers and status.
// - Reset, defaults, flush also reset buffer.
// - Empty or flushed buffer reads zero.
// - Water event below level TX, above RX.
// - Status reports bytes left after reception.
module hif_irq_ctrl
    import hif_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] evt_main,
    input wire logic [7:0] evt_timer,
    input wire logic [7:0] evt_error,
    input wire logic [7:0] evt_target,
    input wire logic rx_start,
    input wire logic link_wr,
    input wire logic [7:0] link_wdata,
    input wire logic link_rd,
    output logic [7:0] link_rdata,
    output logic irq
);
    hif_buf_if hb ();

    logic aw_q;
    logic [7:0] awaddr_q;
    logic w_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic irq_q;
    logic ctrl_q;
    logic [8:0] water_q;
    logic bufrd_q;

    function automatic logic addr_known(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= ADDR_CTRL);
    endfunction

    // Write path: address and data are latched independently, in any order.
    wire logic wr_go = aw_q && w_q && !bvalid_q;
    wire logic wr_ok = addr_known(awaddr_q);
    wire logic cmd_go = wr_go && (awaddr_q == ADDR_CMD) && wstrb_q[0];
    wire hif_cmd_e cmd = hif_cmd_e'(wdata_q[1:0]);
    wire logic cmd_defaults = cmd_go && (cmd == HIF_CMD_DEFAULTS);
    wire logic cmd_halt = cmd_go && (cmd == HIF_CMD_HALT);
    wire logic cmd_flush = cmd_go && (cmd == HIF_CMD_FLUSH);
    wire logic clear_all = cmd_defaults || cmd_halt || cmd_flush;

    // Read path: one read at a time; registers answer the cycle after acceptance, buffer data a cycle later.
    wire logic rd_go = s_axi_arvalid && s_axi_arready;
    wire logic [7:0] ra = s_axi_araddr;

    // Nothing new is taken while a response waits, so a write is never half-latched.
    assign s_axi_awready = !aw_q && !bvalid_q;
    assign s_axi_wready = !w_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q && !bufrd_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign irq = irq_q;

    logic [NUM_GROUPS-1:0][7:0] grp_evt;
    logic [NUM_GROUPS-1:0][7:0] grp_flags;
    logic [NUM_GROUPS-1:0][7:0] grp_mask;
    logic [NUM_GROUPS-1:0] grp_pend;

    // The water-level event lands in the main group.
    assign grp_evt[0] = evt_main | (8'h01 << MAIN_WATER_BIT) & {8{hb.water_evt}};
    assign grp_evt[1] = evt_timer;
    assign grp_evt[2] = evt_error;
    assign grp_evt[3] = evt_target;

    // Four independent status groups.
    generate
        for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
            wire logic [7:0] status_addr = ADDR_IRQ_MAIN + 8'(4 * g);
            wire logic [7:0] mask_addr = ADDR_MASK_MAIN + 8'(4 * g);
            hif_irq_group u_grp (
                .aclk(aclk),
                .aresetn(aresetn),
                .events(grp_evt[g]),
                .read_clear(rd_go && (ra == status_addr)),
                .clear_all(clear_all),
                .mask_we(wr_go && (awaddr_q == mask_addr) && wstrb_q[0]),
                .mask_wdata(wdata_q[7:0]),
                .flags(grp_flags[g]),
                .mask(grp_mask[g]),
                .pending(grp_pend[g])
            );
        end
    endgenerate

    assign hb.host_wr = wr_go && (awaddr_q == ADDR_BUF_DATA) && wstrb_q[0];
    assign hb.host_wdata = wdata_q[7:0];
    assign hb.host_rd = bufrd_q;
    assign hb.flush = cmd_defaults || cmd_flush || rx_start;

    hif_buffer u_buf (
        .aclk(aclk),
        .aresetn(aresetn),
        .hb(hb),
        .tx_mode(ctrl_q),
        .water_level(water_q),
        .link_wr(link_wr),
        .link_wdata(link_wdata),
        .link_rd(link_rd),
        .link_rdata(link_rdata)
    );

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (ra)
            ADDR_IRQ_MAIN: rd_mux = {24'h000000, grp_flags[0]};
            ADDR_IRQ_TIMER: rd_mux = {24'h000000, grp_flags[1]};
            ADDR_IRQ_ERROR: rd_mux = {24'h000000, grp_flags[2]};
            ADDR_IRQ_TARGET: rd_mux = {24'h000000, grp_flags[3]};
            ADDR_MASK_MAIN: rd_mux = {24'h000000, grp_mask[0]};
            ADDR_MASK_TIMER: rd_mux = {24'h000000, grp_mask[1]};
            ADDR_MASK_ERROR: rd_mux = {24'h000000, grp_mask[2]};
            ADDR_MASK_TARGET: rd_mux = {24'h000000, grp_mask[3]};
            ADDR_BUF_STAT1: rd_mux = {24'h000000, hb.count[7:0]};
            ADDR_BUF_STAT2: begin
                rd_mux[STAT2_CNT_HI +: 2] = hb.count[9:8];
                rd_mux[STAT2_UNDERFLOW] = hb.underflow;
                rd_mux[STAT2_OVERFLOW] = hb.overflow;
            end
            ADDR_WATER: rd_mux = {23'h000000, water_q};
            ADDR_CTRL: rd_mux = {31'h00000000, ctrl_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            awaddr_q <= 8'h00;
            w_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // The buffer pop is issued the cycle after acceptance, so data reads take two cycles.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
            bufrd_q <= 1'b0;
        end else begin
            bufrd_q <= 1'b0;
            if (rd_go && ra == ADDR_BUF_DATA && !bufrd_q) begin
                bufrd_q <= 1'b1;
            end else if (bufrd_q) begin
                rvalid_q <= 1'b1;
                rdata_q <= {24'h000000, hb.host_rdata};
                rresp_q <= RESP_OKAY;
            end else if (rd_go) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= addr_known(ra) ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= 1'b0;
            water_q <= WATER_RESET;
            irq_q <= 1'b0;
        end else begin
            if (cmd_defaults) begin
                ctrl_q <= 1'b0;
                water_q <= WATER_RESET;
            end else if (wr_go && awaddr_q == ADDR_CTRL && wstrb_q[0]) begin
                ctrl_q <= wdata_q[CTRL_TX_MODE];
            end else if (wr_go && awaddr_q == ADDR_WATER) begin
                water_q <= wdata_q[8:0];
            end
            irq_q <= |grp_pend;
        end
    end
endmodule

// ==== core/hif_irq_group.sv ====
`timescale 1ns/1ns
module hif_irq_group
    import hif_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [GROUP_BITS-1:0] events,
    input wire logic read_clear,
    input wire logic clear_all,
    input wire logic mask_we,
    input wire logic [GROUP_BITS-1:0] mask_wdata,
    output logic [GROUP_BITS-1:0] flags,
    output logic [GROUP_BITS-1:0] mask,
    output logic pending
);
    logic [GROUP_BITS-1:0] flags_q;
    logic [GROUP_BITS-1:0] flags_d;
    logic [GROUP_BITS-1:0] mask_q;
    wire logic clr = read_clear || clear_all;

    // New events win over a clearing read in the same cycle.
    assign flags_d = (clr ? '0 : flags_q) | events;
    assign flags = flags_q;
    assign mask = mask_q;
    assign pending = |(flags_q & ~mask_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= '0;
            mask_q <= MASK_RESET;
        end else begin
            flags_q <= flags_d;
            if (mask_we) begin
                mask_q <= mask_wdata;
            end
        end
    end
endmodule

// ==== include/hif_buf_if.sv ====
`timescale 1ns/1ns
interface hif_buf_if;
    import hif_pkg::*;
    logic host_wr;
    logic [7:0] host_wdata;
    logic host_rd;
    logic [7:0] host_rdata;
    logic flush;
    logic [CNT_W-1:0] count;
    logic overflow;
    logic underflow;
    logic water_evt;

    modport ctrl (
        output host_wr, host_wdata, host_rd, flush,
        input host_rdata, count, overflow, underflow, water_evt
    );
    modport buffer (
        input host_wr, host_wdata, host_rd, flush,
        output host_rdata, count, overflow, underflow, water_evt
    );
endinterface

// ==== include/hif_pkg.sv ====
package hif_pkg;
    // Register byte addresses on the AXI4-Lite bus.
    localparam logic [7:0] ADDR_IRQ_MAIN = 8'h00;
    localparam logic [7:0] ADDR_IRQ_TIMER = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ERROR = 8'h08;
    localparam logic [7:0] ADDR_IRQ_TARGET = 8'h0C;
    localparam logic [7:0] ADDR_MASK_MAIN = 8'h10;
    localparam logic [7:0] ADDR_MASK_TIMER = 8'h14;
    localparam logic [7:0] ADDR_MASK_ERROR = 8'h18;
    localparam logic [7:0] ADDR_MASK_TARGET = 8'h1C;
    localparam logic [7:0] ADDR_BUF_DATA = 8'h20;
    localparam logic [7:0] ADDR_BUF_STAT1 = 8'h24;
    localparam logic [7:0] ADDR_BUF_STAT2 = 8'h28;
    localparam logic [7:0] ADDR_WATER = 8'h2C;
    localparam logic [7:0] ADDR_CMD = 8'h30;
    localparam logic [7:0] ADDR_CTRL = 8'h34;

    localparam int NUM_GROUPS = 4;
    localparam int GROUP_BITS = 8;
    localparam int BUF_DEPTH = 512;
    localparam int PTR_W = 9;
    localparam int CNT_W = 10;

    // Fields of the second buffer status register.
    localparam int STAT2_CNT_HI = 0;
    localparam int STAT2_UNDERFLOW = 4;
    localparam int STAT2_OVERFLOW = 5;

    // Control register fields.
    localparam int CTRL_TX_MODE = 0;

    // Main event group bit that the buffer drives.
    localparam int MAIN_WATER_BIT = 3;

    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [8:0] WATER_RESET = 9'h040;

    typedef enum logic [1:0] {
        HIF_CMD_NONE = 2'b00,
        HIF_CMD_DEFAULTS = 2'b01,
        HIF_CMD_HALT = 2'b10,
        HIF_CMD_FLUSH = 2'b11
    } hif_cmd_e;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
